//--- core/i2c_fifo_flow_control.sv
// Purpose: transmit/receive FIFO control of a two-wire serial interface
// Assumes: shifter and frame error detectors run on clk_sys; scl/sda pins are async
// Notes:   one wait state on every APB access; prdata comes from a flop
// Operation
// R1: multiple data mode moves 1, 2 or 4 entries per byte, halfword, word access
// R2: ready granularity fields select 1, 2 or 4 entries for the ready flags
// R3: tx granularity 0x2 raises tx ready only with room for four entries
// R4: rx granularity 0x2 raises rx ready only with four unread entries
// R5: software sets both granularities to match the DMA transfer size
// R6: early frame end by nack, timeout or code-ack error locks tx FIFO
// R7: lock state is readable in the status register
// R8: writing one to the lock clear command releases the lock
// R9: writing the holding register while full sets tx pointer error
// R10: multi-entry write larger than free space sets tx pointer error
// R11: multi-entry read larger than unread entries sets rx pointer error
// R12: after a pointer error software issues reset and ignores other flags
// R13: software should check ready flags or levels before each access
// R14: bus clear command clocks the bus until the slave frees data line
// R15: tx and rx level fields give entries held, compared with thresholds
// R16: tx threshold flag sets when level falls from above to at/below
// R17: rx threshold flag sets when level rises from below to at/above
// R18: each threshold crossing can also raise the interrupt
// R19: pointer error flags stay set until the software reset command
//
// The register offsets and the APB interface to the registers were left to the implementer.
`timescale 1ns/1ps
module i2c_fifo_flow_control #(
  parameter int DEPTH = 16
) (
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        resetn,

  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,

  // serial shifter side
  input  wire logic        txPopReq,
  output logic [7:0]       txData,
  output logic             frameStartOk,
  input  wire logic        rxPush,
  input  wire logic [7:0]  rxData,
  output logic             rxSpace,

  // frame error detectors
  input  wire logic        nackErr,
  input  wire logic        smbusTimeoutErr,
  input  wire logic        masterCodeAckErr,

  // bus pins
  input  wire logic        sclIn,
  output logic             sclOut,
  output logic             sclOe,
  input  wire logic        serialDataLineIn,

  // interrupt
  output logic             irq
);
  localparam int AW = $clog2(DEPTH);
  localparam int L  = i2c_fifo_pkg::LVL_W;
  localparam logic [L-1:0] DEPTH_L = L'(DEPTH);

  logic [31:0]  modeReg;
  logic [i2c_fifo_pkg::EV_W-1:0] isr;
  logic [i2c_fifo_pkg::EV_W-1:0] ier;
  logic [7:0]   txMem [DEPTH];
  logic [7:0]   rxMem [DEPTH];
  logic [AW-1:0] txWptr, txRptr, rxWptr, rxRptr;
  logic [L-1:0] txLevel, rxLevel;
  logic [L-1:0] next_txLevel, next_rxLevel;
  logic         lock, txThrFlag, rxThrFlag, txPteFlag, rxPteFlag;
  logic         ackQ;
  logic         sclS1, sclS2, sclS3, sdaS1, sdaS2;
  i2c_fifo_pkg::busclr_state_t bcState;
  logic [11:0]  bcCnt;
  logic [3:0]   bcPulses;

  // apb handshake: one wait state so read data can come from a flop
  wire accessPh = psel & penable;
  wire wrFire   = accessPh & pwrite & ackQ;
  wire rdFire   = accessPh & ~pwrite & ~ackQ;
  assign pready = ackQ;

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) ackQ <= 1'b0;
    else         ackQ <= accessPh & ~ackQ;
  end

  // mode fields
  wire          multiMode = modeReg[i2c_fifo_pkg::MODE_MULTI];
  wire [1:0]    txGran = modeReg[i2c_fifo_pkg::MODE_TXG_LSB +: i2c_fifo_pkg::GRAN_W];
  wire [1:0]    rxGran = modeReg[i2c_fifo_pkg::MODE_RXG_LSB +: i2c_fifo_pkg::GRAN_W];
  wire [L-1:0]  txThresh = modeReg[i2c_fifo_pkg::MODE_TXT_LSB +: L];
  wire [L-1:0]  rxThresh = modeReg[i2c_fifo_pkg::MODE_RXT_LSB +: L];

  function automatic logic [L-1:0] granNeed(input logic [1:0] g);
    granNeed = (g == 2'h0) ? L'(1) : (g == 2'h1) ? L'(2) : L'(4);
  endfunction

  // decoded commands
  wire ctrlWr    = wrFire && (paddr == i2c_fifo_pkg::OFF_CTRL);
  wire swReset   = ctrlWr & pwdata[i2c_fifo_pkg::CTRL_SRST];
  wire lockClr   = ctrlWr & pwdata[i2c_fifo_pkg::CTRL_LOCK_CLR];
  wire busClrCmd = ctrlWr & pwdata[i2c_fifo_pkg::CTRL_BUSCLR];
  wire thrWr     = wrFire && (paddr == i2c_fifo_pkg::OFF_THR);
  wire rhrRd     = rdFire && (paddr == i2c_fifo_pkg::OFF_RHR_B ||
                   paddr == i2c_fifo_pkg::OFF_RHR_H || paddr == i2c_fifo_pkg::OFF_RHR_W);
  wire fstatRd   = rdFire && (paddr == i2c_fifo_pkg::OFF_FSTAT);

  // entries per access, from byte strobes on write, offset on read
  wire [L-1:0] wrN = !multiMode ? L'(1) : (pstrb == 4'hF) ? L'(4) : // R1
                     (pstrb == 4'h3) ? L'(2) : L'(1);
  wire [L-1:0] rdN = !multiMode ? L'(1) : (paddr == i2c_fifo_pkg::OFF_RHR_W) ? L'(4) : // R1
                     (paddr == i2c_fifo_pkg::OFF_RHR_H) ? L'(2) : L'(1);

  // transmit side
  wire [L-1:0] txFree  = DEPTH_L - txLevel;
  wire txPteEv  = thrWr && (wrN > txFree); // R9 R10
  wire [L-1:0] txPushN = (thrWr && !txPteEv) ? wrN : L'(0);
  wire txPop    = txPopReq && frameStartOk;
  assign frameStartOk = (txLevel != L'(0)) && !lock; // R6
  assign txData = txMem[txRptr];
  wire lockEv   = nackErr | smbusTimeoutErr | masterCodeAckErr;
  assign next_txLevel = txLevel + txPushN - L'(txPop); // R15

  // receive side
  wire rxPteEv  = rhrRd && multiMode && (rdN > rxLevel); // R11
  wire [L-1:0] rxPopN = (rhrRd && !rxPteEv && rdN <= rxLevel) ? rdN : L'(0);
  assign rxSpace = (rxLevel != DEPTH_L);
  wire rxIn     = rxPush && rxSpace;
  assign next_rxLevel = rxLevel + L'(rxIn) - rxPopN; // R15

  // ready flags follow the chosen granularity
  wire txReadyFlag = txFree >= granNeed(txGran); // R2 R3
  wire rxReadyFlag = rxLevel >= granNeed(rxGran); // R2 R4

  // threshold crossings
  wire txThrEv = (txLevel > txThresh) && (next_txLevel <= txThresh); // R16
  wire rxThrEv = (rxLevel < rxThresh) && (next_rxLevel >= rxThresh); // R17

  // transmit fifo storage, lane order low byte first
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      txWptr  <= '0;
      txRptr  <= '0;
      txLevel <= '0;
    end else if (swReset) begin
      txWptr  <= '0;
      txRptr  <= '0;
      txLevel <= '0;
    end else begin
      for (int i = 0; i < 4; i++) begin
        if (L'(i) < txPushN) txMem[AW'(txWptr + AW'(i))] <= pwdata[8*i +: 8]; // R1
      end
      txWptr  <= AW'(txWptr + AW'(txPushN));
      txRptr  <= AW'(txRptr + AW'(txPop));
      txLevel <= next_txLevel;
    end
  end

  // receive fifo storage
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      rxWptr  <= '0;
      rxRptr  <= '0;
      rxLevel <= '0;
    end else if (swReset) begin
      rxWptr  <= '0;
      rxRptr  <= '0;
      rxLevel <= '0;
    end else begin
      if (rxIn) rxMem[rxWptr] <= rxData;
      rxWptr  <= AW'(rxWptr + AW'(rxIn));
      rxRptr  <= AW'(rxRptr + AW'(rxPopN));
      rxLevel <= next_rxLevel;
    end
  end

  // read word gathered from up to four unread entries
  logic [31:0] rhrWord;
  always_comb begin
    rhrWord = 32'h0000_0000;
    for (int i = 0; i < 4; i++) begin
      if (L'(i) < rxPopN) rhrWord[8*i +: 8] = rxMem[AW'(rxRptr + AW'(i))];
    end
  end

  // transmit lock: a new error wins over a clear in the same cycle
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn)      lock <= 1'b0;
    else if (lockEv)  lock <= 1'b1; // R6
    else if (lockClr) lock <= 1'b0; // R8
    else if (swReset) lock <= 1'b0;
  end

  // pointer errors stick; only the software reset command drops them
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      txPteFlag <= 1'b0;
      rxPteFlag <= 1'b0;
    end else begin
      txPteFlag <= txPteEv | (txPteFlag & ~swReset); // R9 R10 R19
      rxPteFlag <= rxPteEv | (rxPteFlag & ~swReset); // R11 R19
    end
  end

  // threshold flags clear on fifo status read, a new crossing wins
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      txThrFlag <= 1'b0;
      rxThrFlag <= 1'b0;
    end else begin
      txThrFlag <= txThrEv | (txThrFlag & ~fstatRd & ~swReset); // R16
      rxThrFlag <= rxThrEv | (rxThrFlag & ~fstatRd & ~swReset); // R17
    end
  end

  // sticky interrupt status, write-one clear, set wins
  wire [i2c_fifo_pkg::EV_W-1:0] evVec = {lockEv, rxPteEv, txPteEv, rxThrEv, txThrEv};
  wire icrWr = wrFire && (paddr == i2c_fifo_pkg::OFF_ICR);
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn)    isr <= '0;
    else if (icrWr) isr <= evVec | (isr & ~pwdata[i2c_fifo_pkg::EV_W-1:0]);
    else            isr <= evVec | isr; // R18
  end
  assign irq = |(isr & ier); // R18

  // writable configuration
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      modeReg <= i2c_fifo_pkg::MODE_RST;
      ier     <= '0;
    end else if (wrFire) begin
      if (paddr == i2c_fifo_pkg::OFF_MODE)     modeReg <= pwdata;
      else if (paddr == i2c_fifo_pkg::OFF_IER) ier <= pwdata[i2c_fifo_pkg::EV_W-1:0];
    end
  end

  // pin synchronisers; first stages feed only the second
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      {sclS1, sclS2, sclS3} <= 3'h7;
      {sdaS1, sdaS2}        <= 2'h3;
    end else begin
      sclS1 <= sclIn;
      sclS2 <= sclS1;
      sclS3 <= sclS2;
      sdaS1 <= serialDataLineIn;
      sdaS2 <= sdaS1;
    end
  end

  wire sclRise = sclS2 & ~sclS3;

  // bus clear: pull clock low, release, count observed rising edges;
  // stops once the data line reads high or all pulses are sent
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      bcState  <= i2c_fifo_pkg::BC_IDLE;
      bcCnt    <= '0;
      bcPulses <= '0;
    end else begin
      case (bcState)
        i2c_fifo_pkg::BC_IDLE: begin
          bcCnt    <= '0;
          bcPulses <= '0;
          if (busClrCmd) bcState <= i2c_fifo_pkg::BC_LOW; // R14
        end
        i2c_fifo_pkg::BC_LOW: begin
          if (bcCnt == 12'(i2c_fifo_pkg::BUSCLR_HALF_CYC - 1)) begin
            bcCnt   <= '0;
            bcState <= i2c_fifo_pkg::BC_HIGH;
          end else begin
            bcCnt <= bcCnt + 12'h001;
          end
        end
        default: begin
          if (sclRise) bcPulses <= bcPulses + 4'h1; // R14
          if (bcCnt == 12'(i2c_fifo_pkg::BUSCLR_HALF_CYC - 1)) begin
            bcCnt <= '0;
            if (sdaS2 || bcPulses >= 4'(i2c_fifo_pkg::BUSCLR_PULSES))
              bcState <= i2c_fifo_pkg::BC_IDLE;
            else
              bcState <= i2c_fifo_pkg::BC_LOW;
          end else begin
            bcCnt <= bcCnt + 12'h001;
          end
        end
      endcase
    end
  end
  // only ever pulled low; the pull-up makes the high phase
  assign sclOut = 1'b0;
  assign sclOe  = (bcState == i2c_fifo_pkg::BC_LOW);
  wire bcBusy   = (bcState != i2c_fifo_pkg::BC_IDLE);

  // registers fill every aligned word up to the enable register,
  // so a range test replaces a compare per offset
  wire mapped = (paddr[1:0] == 2'h0) && (paddr <= i2c_fifo_pkg::OFF_IER);
  // read data captured in the first access cycle
  assign pslverr = accessPh & ackQ & ~mapped;

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      prdata <= 32'h0000_0000;
    end else if (rdFire) begin
      prdata <= 32'h0000_0000;
      if (paddr == i2c_fifo_pkg::OFF_MODE) begin
        prdata <= modeReg;
      end else if (paddr == i2c_fifo_pkg::OFF_STATUS) begin
        prdata[i2c_fifo_pkg::ST_TX_RDY] <= txReadyFlag;
        prdata[i2c_fifo_pkg::ST_RX_RDY] <= rxReadyFlag;
        prdata[i2c_fifo_pkg::ST_LOCK]   <= lock; // R7
        prdata[i2c_fifo_pkg::ST_BUSCLR] <= bcBusy;
      end else if (paddr == i2c_fifo_pkg::OFF_FSTAT) begin
        prdata[i2c_fifo_pkg::FS_TXTHF] <= txThrFlag;
        prdata[i2c_fifo_pkg::FS_RXTHF] <= rxThrFlag;
        prdata[i2c_fifo_pkg::FS_TXPTE] <= txPteFlag;
        prdata[i2c_fifo_pkg::FS_RXPTE] <= rxPteFlag;
        prdata[i2c_fifo_pkg::FS_TXLV_LSB +: L] <= txLevel; // R15
        prdata[i2c_fifo_pkg::FS_RXLV_LSB +: L] <= rxLevel; // R15
      end else if (rhrRd) begin
        prdata <= rhrWord; // R1
      end else if (paddr == i2c_fifo_pkg::OFF_ISR) begin
        prdata[i2c_fifo_pkg::EV_W-1:0] <= isr;
      end else if (paddr == i2c_fifo_pkg::OFF_IER) begin
        prdata[i2c_fifo_pkg::EV_W-1:0] <= ier;
      end
    end
  end

  // checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);

  a_tx_ready_four: assert property (txGran == 2'h2 |-> txReadyFlag == (txFree >= L'(4))) // R3
    else $error("tx ready wrong at granularity four");

  a_rx_ready_four: assert property (rxGran == 2'h2 |-> rxReadyFlag == (rxLevel >= L'(4))) // R4
    else $error("rx ready wrong at granularity four");

  a_lock_blocks_frame: assert property (lockEv |=> lock && !frameStartOk) // R6
    else $error("frame error did not lock tx fifo");

  a_lock_release: assert property (lockClr && !lockEv |=> !lock ##1 (!lock || $past(lockEv))) // R8
    else $error("lock clear did not release");

  // a pop in the same cycle still drains one entry
  a_tx_full_error: assert property (thrWr && txLevel == DEPTH_L |=> txPteFlag && // R9
    txLevel == $past(txLevel) - L'($past(txPop)))
    else $error("write to full tx fifo missed pointer error");

  a_rx_under_error: assert property (rhrRd && multiMode && rdN > rxLevel |=> rxPteFlag) // R11
    else $error("over-read missed rx pointer error");

  a_pte_sticky: assert property (txPteFlag && !swReset |=> txPteFlag) // R19
    else $error("tx pointer error cleared without reset");

  a_thr_irq_path: assert property (txThrEv && ier[i2c_fifo_pkg::EV_TXTH] |=> txThrFlag ##0 irq) // R16 R18
    else $error("tx threshold crossing lost");

  // main scenarios reached
  c_multi_word: cover property (thrWr && wrN == L'(4) && !txPteEv);
  c_lock_then_clear: cover property (lockEv ##[1:20] lockClr);
  c_bus_clear: cover property (busClrCmd ##1 bcBusy);
endmodule // i2c_fifo_flow_control

//--- core/i2c_fifo_pkg.sv
// Purpose: shared constants and types for the two-wire FIFO flow control
// Assumes: APB register bus, 32-bit data, byte offsets below
// Notes:   level fields are LVL_W bits wide, so the FIFO depth stays at or below 63
package i2c_fifo_pkg;
  // register byte offsets
  localparam logic [7:0] OFF_CTRL   = 8'h00;
  localparam logic [7:0] OFF_MODE   = 8'h04;
  localparam logic [7:0] OFF_STATUS = 8'h08;
  localparam logic [7:0] OFF_FSTAT  = 8'h0C;
  localparam logic [7:0] OFF_THR    = 8'h10;
  localparam logic [7:0] OFF_RHR_B  = 8'h14;
  localparam logic [7:0] OFF_RHR_H  = 8'h18;
  localparam logic [7:0] OFF_RHR_W  = 8'h1C;
  localparam logic [7:0] OFF_ISR    = 8'h20;
  localparam logic [7:0] OFF_ICR    = 8'h24;
  localparam logic [7:0] OFF_IER    = 8'h28;
  // control command bits
  localparam int CTRL_LOCK_CLR = 0;
  localparam int CTRL_SRST     = 1;
  localparam int CTRL_BUSCLR   = 2;
  // mode register fields
  localparam int MODE_MULTI   = 0;
  localparam int MODE_TXG_LSB = 4;
  localparam int MODE_RXG_LSB = 8;
  localparam int MODE_TXT_LSB = 16;
  localparam int MODE_RXT_LSB = 24;
  localparam int GRAN_W       = 2;
  localparam int LVL_W        = 6;
  localparam logic [31:0] MODE_RST = 32'h0000_0000;
  // status and fifo status bits
  localparam int ST_TX_RDY   = 0;
  localparam int ST_RX_RDY   = 1;
  localparam int ST_LOCK     = 2;
  localparam int ST_BUSCLR   = 3;
  localparam int FS_TXTHF    = 0;
  localparam int FS_RXTHF    = 1;
  localparam int FS_TXPTE    = 2;
  localparam int FS_RXPTE    = 3;
  localparam int FS_TXLV_LSB = 8;
  localparam int FS_RXLV_LSB = 16;
  // interrupt event bits
  localparam int EV_W     = 5;
  localparam int EV_TXTH  = 0;
  localparam int EV_RXTH  = 1;
  localparam int EV_TXPTE = 2;
  localparam int EV_RXPTE = 3;
  localparam int EV_LOCK  = 4;
  // bus clear timing
  localparam int CLK_MHZ         = 250;
  localparam int BUSCLR_HALF_NS  = 5000;
  localparam int BUSCLR_HALF_CYC = (BUSCLR_HALF_NS * CLK_MHZ) / 1000;
  localparam int BUSCLR_PULSES   = 9;
  typedef enum {BC_IDLE, BC_LOW, BC_HIGH} busclr_state_t;
endpackage

//--- tb/i2c_fifo_flow_control_test.sv
// Purpose: self-checking bench for the two-wire FIFO flow control
// Assumes: APB master here, shifter model on the far side
// Notes:   data random from a fixed seed; levels read back through FSTAT
`timescale 1ns/1ps
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin nErrors++; \
  $display("[FAIL] %s expected %0h seen %0h", nm, e, g); end end
module i2c_fifo_flow_control_test;
  logic        clk_sys, resetn, psel, penable, pwrite, pready, pslverr, rerr;
  logic [7:0]  paddr, txData, rxData, pushByte, lastPop, e;
  logic [31:0] pwdata, prdata, rdat, w;
  logic [3:0]  pstrb, sclRises;
  logic        txPopReq, frameStartOk, rxPush, rxSpace, nackErr, smbusTimeoutErr;
  logic        masterCodeAckErr, sclIn, sclOut, sclOe, serialDataLineIn, irq;
  logic        popEn, pushEn, holdSda;
  logic [7:0]  txQ[$], rxQ[$];
  int          nErrors, comparisons, tt, rt, n;
  i2c_fifo_flow_control u_i2c_fifo_flow_control (.clk_sys, .resetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .txPopReq, .txData, .frameStartOk,
    .rxPush, .rxData, .rxSpace, .nackErr, .smbusTimeoutErr, .masterCodeAckErr, .sclIn, .sclOut,
    .sclOe, .serialDataLineIn, .irq);
  i2c_shifter_model u_i2c_shifter_model (.clk_sys, .resetn, .popEn, .pushEn, .pushByte,
    .holdSda, .lastPop, .sclRises, .txPopReq, .txData, .frameStartOk, .rxPush, .rxData,
    .rxSpace, .sclIn, .sclOut, .sclOe, .serialDataLineIn);
  // 250 MHz system clock
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  task automatic finishTest();
    $display("comparisons %0d mismatches %0d", comparisons, nErrors);
    if (nErrors == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // one APB transfer; request held until pready is seen at an edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     input logic [3:0] s);
    int k;
    k = 0;
    @(posedge clk_sys);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    pstrb   <= s;
    @(posedge clk_sys);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys);
      k++;
    end while (pready !== 1'b1 && k < 64);
    rdat    = prdata;
    rerr    = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      nErrors++;
      finishTest();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d); apb(1'b1, a, d, 4'hF); endtask
  task automatic rd(input logic [7:0] a); apb(1'b0, a, 32'h0, 4'hF); endtask
  task automatic rdFs(); rd(i2c_fifo_pkg::OFF_FSTAT); endtask
  task automatic softReset(); wr(i2c_fifo_pkg::OFF_CTRL, 32'h1 << i2c_fifo_pkg::CTRL_SRST); endtask
  // word writes, byte 0 queued first
  task automatic fillTx(input int nw);
    logic [31:0] v;
    for (int i = 0; i < nw; i++) begin
      v = $urandom;
      for (int b = 0; b < 4; b++) txQ.push_back(v[8*b +: 8]);
      wr(i2c_fifo_pkg::OFF_THR, v);
    end
  endtask
  task automatic pop();
    @(posedge clk_sys);
    popEn <= 1'b1;
    @(posedge clk_sys);
    popEn <= 1'b0;
  endtask
  task automatic push(input logic [7:0] b);
    @(posedge clk_sys);
    pushByte <= b;
    pushEn   <= 1'b1;
    @(posedge clk_sys);
    pushEn   <= 1'b0;
  endtask
  function automatic logic [31:0] modeVal(input logic m, input logic [1:0] tg, rg,
                                          input logic [5:0] t, r);
    return (32'(m) << i2c_fifo_pkg::MODE_MULTI) | (32'(tg) << i2c_fifo_pkg::MODE_TXG_LSB)
         | (32'(rg) << i2c_fifo_pkg::MODE_RXG_LSB) | (32'(t) << i2c_fifo_pkg::MODE_TXT_LSB)
         | (32'(r) << i2c_fifo_pkg::MODE_RXT_LSB);
  endfunction
  function automatic int need(input int g);
    return (g == 0) ? 1 : (g == 1) ? 2 : 4;
  endfunction
  // main sequence
  initial begin
    {resetn, psel, penable, pwrite, popEn, pushEn, holdSda} = 7'h00;
    {nackErr, smbusTimeoutErr, masterCodeAckErr} = 3'h0;
    {paddr, pushByte, pstrb, pwdata} = 52'h0;
    nErrors = 0;
    comparisons = 0;
    void'($urandom(96815));
    repeat (8) @(posedge clk_sys);
    resetn <= 1'b1;
    rd(i2c_fifo_pkg::OFF_MODE);
    `CHK("mode", i2c_fifo_pkg::MODE_RST, rdat)
    rd(i2c_fifo_pkg::OFF_STATUS);
    `CHK("status", 4'h1, rdat[3:0])
    rdFs();
    `CHK("fstat", 32'h0, rdat)
    rd(8'h40);
    `CHK("slverr", 1'b1, rerr)
    wr(i2c_fifo_pkg::OFF_IER, 32'h1F);
    $display("test reset done");
    // room-for-four ready flag, then a full FIFO hit by a single write
    wr(i2c_fifo_pkg::OFF_MODE, modeVal(1'b1, 2'h2, 2'h2, 6'h0, 6'h0));
    fillTx(3);
    rd(i2c_fifo_pkg::OFF_STATUS);
    `CHK("tx ready 12", 1'b1, rdat[i2c_fifo_pkg::ST_TX_RDY])
    fillTx(1);
    rd(i2c_fifo_pkg::OFF_STATUS);
    `CHK("tx ready 16", 1'b0, rdat[i2c_fifo_pkg::ST_TX_RDY])
    wr(i2c_fifo_pkg::OFF_MODE, modeVal(1'b0, 2'h0, 2'h0, 6'h0, 6'h0));
    wr(i2c_fifo_pkg::OFF_THR, $urandom);
    rdFs();
    `CHK("txpte", 1'b1, rdat[i2c_fifo_pkg::FS_TXPTE])
    `CHK("txlvl 16", 6'd16, rdat[i2c_fifo_pkg::FS_TXLV_LSB +: i2c_fifo_pkg::LVL_W])
    rdFs();
    `CHK("txpte held", 1'b1, rdat[i2c_fifo_pkg::FS_TXPTE])
    softReset();
    rdFs();
    `CHK("soft reset", 32'h0, rdat)
    txQ.delete();
    // multi write beyond free space, granularity sweep at two free entries
    wr(i2c_fifo_pkg::OFF_MODE, modeVal(1'b1, 2'h2, 2'h2, 6'h0, 6'h0));
    fillTx(3);
    apb(1'b1, i2c_fifo_pkg::OFF_THR, $urandom, 4'h3);
    for (int g = 0; g < 3; g++) begin
      wr(i2c_fifo_pkg::OFF_MODE, modeVal(1'b1, g[1:0], 2'h2, 6'h0, 6'h0));
      rd(i2c_fifo_pkg::OFF_STATUS);
      `CHK("tx ready gran", (2 >= need(g)), rdat[i2c_fifo_pkg::ST_TX_RDY])
    end
    wr(i2c_fifo_pkg::OFF_ICR, 32'h1F);
    wr(i2c_fifo_pkg::OFF_THR, $urandom);
    rdFs();
    `CHK("txpte multi", 1'b1, rdat[i2c_fifo_pkg::FS_TXPTE])
    `CHK("txlvl 14", 6'd14, rdat[i2c_fifo_pkg::FS_TXLV_LSB +: i2c_fifo_pkg::LVL_W])
    rd(i2c_fifo_pkg::OFF_ISR);
    `CHK("isr txpte", 32'h1 << i2c_fifo_pkg::EV_TXPTE, rdat)
    softReset();
    txQ.delete();
    $display("test tx pointer done");
    // each frame error locks the FIFO until the clear command
    tt = $urandom_range(14, 1);
    wr(i2c_fifo_pkg::OFF_MODE, modeVal(1'b1, 2'h0, 2'h0, tt[5:0], 6'h0));
    fillTx(4);
    for (int k = 0; k < 3; k++) begin
      wr(i2c_fifo_pkg::OFF_ICR, 32'h1F);
      nackErr          <= (k == 0);
      smbusTimeoutErr  <= (k == 1);
      masterCodeAckErr <= (k == 2);
      @(posedge clk_sys);
      {nackErr, smbusTimeoutErr, masterCodeAckErr} <= 3'h0;
      @(negedge clk_sys);
      `CHK("start held", 1'b0, frameStartOk)
      pop();
      rd(i2c_fifo_pkg::OFF_STATUS);
      `CHK("lock", 1'b1, rdat[i2c_fifo_pkg::ST_LOCK])
      rdFs();
      `CHK("no pop", 6'd16, rdat[i2c_fifo_pkg::FS_TXLV_LSB +: i2c_fifo_pkg::LVL_W])
      rd(i2c_fifo_pkg::OFF_ISR);
      `CHK("isr lock", 32'h1 << i2c_fifo_pkg::EV_LOCK, rdat)
      @(negedge clk_sys);
      `CHK("irq lock", 1'b1, irq)
      wr(i2c_fifo_pkg::OFF_IER, 32'h0);
      @(negedge clk_sys);
      `CHK("irq masked", 1'b0, irq)
      wr(i2c_fifo_pkg::OFF_IER, 32'h1F);
      wr(i2c_fifo_pkg::OFF_CTRL, 32'h1 << i2c_fifo_pkg::CTRL_LOCK_CLR);
      rd(i2c_fifo_pkg::OFF_STATUS);
      `CHK("unlock", 1'b0, rdat[i2c_fifo_pkg::ST_LOCK])
      `CHK("start ok", 1'b1, frameStartOk)
    end
    $display("test lock done");
    // drain through the transmit threshold
    wr(i2c_fifo_pkg::OFF_ICR, 32'h1F);
    for (int i = 15; i >= 0; i--) begin
      pop();
      e = txQ.pop_front();
      rdFs();
      `CHK("pop order", e, lastPop)
      `CHK("txlvl", i[5:0], rdat[i2c_fifo_pkg::FS_TXLV_LSB +: i2c_fifo_pkg::LVL_W])
      `CHK("txthf", (i == tt), rdat[i2c_fifo_pkg::FS_TXTHF])
      if (i == tt) begin
        @(negedge clk_sys);
        `CHK("irq txth", 1'b1, irq)
        wr(i2c_fifo_pkg::OFF_ICR, 32'h1F);
      end
    end
    $display("test tx threshold done");
    // receive side: ready at four, threshold, word and halfword reads, over-read
    rt = $urandom_range(8, 1);
    wr(i2c_fifo_pkg::OFF_MODE, modeVal(1'b1, 2'h0, 2'h2, 6'h0, rt[5:0]));
    for (int i = 1; i <= 8; i++) begin
      w = $urandom;
      rxQ.push_back(w[7:0]);
      push(w[7:0]);
      rdFs();
      `CHK("rxlvl", i[5:0], rdat[i2c_fifo_pkg::FS_RXLV_LSB +: i2c_fifo_pkg::LVL_W])
      `CHK("rxthf", (i == rt), rdat[i2c_fifo_pkg::FS_RXTHF])
      rd(i2c_fifo_pkg::OFF_STATUS);
      `CHK("rx ready", (i >= 4), rdat[i2c_fifo_pkg::ST_RX_RDY])
    end
    rd(i2c_fifo_pkg::OFF_ISR);
    `CHK("isr rxth", 1'b1, rdat[i2c_fifo_pkg::EV_RXTH])
    rd(i2c_fifo_pkg::OFF_RHR_W);
    `CHK("word read", {rxQ[3], rxQ[2], rxQ[1], rxQ[0]}, rdat)
    rd(i2c_fifo_pkg::OFF_RHR_H);
    `CHK("half read", {rxQ[5], rxQ[4]}, rdat[15:0])
    rd(i2c_fifo_pkg::OFF_RHR_W);
    `CHK("over-read", 32'h0, rdat)
    rdFs();
    `CHK("rxpte", 1'b1, rdat[i2c_fifo_pkg::FS_RXPTE])
    `CHK("rxlvl 2", 6'd2, rdat[i2c_fifo_pkg::FS_RXLV_LSB +: i2c_fifo_pkg::LVL_W])
    softReset();
    $display("test rx done");
    // bus clear frees a slave holding the data line
    @(posedge clk_sys);
    holdSda <= 1'b1;
    @(posedge clk_sys);
    holdSda <= 1'b0;
    wr(i2c_fifo_pkg::OFF_CTRL, 32'h1 << i2c_fifo_pkg::CTRL_BUSCLR);
    rd(i2c_fifo_pkg::OFF_STATUS);
    `CHK("busclr busy", 1'b1, rdat[i2c_fifo_pkg::ST_BUSCLR])
    n = 0;
    do begin
      rd(i2c_fifo_pkg::OFF_STATUS);
      n++;
    end while (rdat[i2c_fifo_pkg::ST_BUSCLR] !== 1'b0 && n < 4000);
    `CHK("busclr end", 1'b0, rdat[i2c_fifo_pkg::ST_BUSCLR])
    `CHK("scl pulses", 4'h2, sclRises)
    `CHK("data free", 1'b1, serialDataLineIn)
    `CHK("scl released", 1'b0, sclOe)
    $display("test bus clear done");
    finishTest();
  end
endmodule  // i2c_fifo_flow_control_test

//--- tb/i2c_shifter_model.sv
// Purpose: far-side model of the serial shifter and of a slave on the bus
// Assumes: bench requests change just after a rising clk_sys edge
// Notes:   both bus lines pulled up; a stuck slave frees data after two clock pulses
`timescale 1ns/1ps
module i2c_shifter_model (
  // clock and reset
  input  wire logic       clk_sys,
  input  wire logic       resetn,
  // bench commands
  input  wire logic       popEn,
  input  wire logic       pushEn,
  input  wire logic [7:0] pushByte,
  input  wire logic       holdSda,
  output logic [7:0]      lastPop,
  output logic [3:0]      sclRises,
  // shifter side of the design
  output logic            txPopReq,
  input  wire logic [7:0] txData,
  input  wire logic       frameStartOk,
  output logic            rxPush,
  output logic [7:0]      rxData,
  input  wire logic       rxSpace,
  // bus pins
  output logic            sclIn,
  input  wire logic       sclOut,
  input  wire logic       sclOe,
  output logic            serialDataLineIn
);
  logic slaveHold;
  logic sclLast;
  // requests follow the bench; a push with no room is dropped
  assign txPopReq = popEn;
  assign rxPush   = pushEn & rxSpace;
  // idle data shows the inverse so a stale byte never matches
  assign rxData   = rxPush ? pushByte : ~pushByte;
  // pull-ups on both lines
  assign sclIn            = sclOe ? sclOut : 1'b1;
  assign serialDataLineIn = ~slaveHold;
  // capture the byte the design hands over
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) lastPop <= 8'h00;
    else if (txPopReq && frameStartOk) lastPop <= txData;
  end
  // stuck slave, released on the second rising clock edge
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      slaveHold <= 1'b0;
      sclLast   <= 1'b1;
      sclRises  <= 4'h0;
    end else begin
      sclLast <= sclIn;
      if (holdSda) begin
        slaveHold <= 1'b1;
        sclRises  <= 4'h0;
      end else if (sclIn && !sclLast) begin
        sclRises <= sclRises + 4'h1;
        if (sclRises == 4'h1) slaveHold <= 1'b0;
      end
    end
  end
endmodule  // i2c_shifter_model
